/* File: eds_pkg.sv */
// Package of constants and types for the dual mode stream block
package eds_pkg;

  // Array geometry
  localparam int EDS_MEM_DEPTH = 128;
  localparam int EDS_ADDR_W = 7;
  localparam int EDS_BYTE_W = 8;
  localparam logic [6:0] EDS_ADDR_RESET = 7'h00;
  localparam logic [6:0] EDS_ADDR_LAST = 7'h7f;

  // Transmit-only framing
  localparam logic [3:0] EDS_SYNC_EDGES = 4'h9;
  localparam logic [3:0] EDS_NULL_BIT = 4'h8;
  localparam logic [3:0] EDS_BIT_FIRST = 4'h0;

  // Data buffer
  localparam int EDS_FIFO_DEPTH = 4;

  // SDA hold after SCL falls, in ns, and its cycle count (least time, rounded up)
  localparam int EDS_CLK_PERIOD_NS = 8;
  localparam int EDS_SDA_HOLD_NS = 300;
  localparam int EDS_HOLD_CYC_INT = (EDS_SDA_HOLD_NS + EDS_CLK_PERIOD_NS - 1) / EDS_CLK_PERIOD_NS;
  localparam logic [5:0] EDS_HOLD_CYC = 6'(EDS_HOLD_CYC_INT);

  // Operating modes, Gray along power-up path
  typedef enum logic [1:0] {
    EDS_SYNC = 2'b00,
    EDS_STREAM = 2'b01,
    EDS_BIDIR = 2'b11
  } eds_mode_t;

  // Array address step with wrap
  function automatic logic [6:0] eds_next_addr(input logic [6:0] a);
    eds_next_addr = (a == EDS_ADDR_LAST) ? EDS_ADDR_RESET : 7'(a + 7'h01);
  endfunction

endpackage

/* File: eds_mem.sv */
// Byte array of the device with registered read data
module eds_mem
  import eds_pkg::*;
(
  // Clock
  input wire logic clk,
  input wire logic clk_en,
  // Read port
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  // Write port
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data
);

  logic [7:0] cells [EDS_MEM_DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // Array has no reset: contents are nonvolatile
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
    if (clk_en && rd_en)
    begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule // eds_mem

/* File: eds_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
module eds_fifo
  import eds_pkg::*;
#(
  parameter int W = 8,
  parameter int D = EDS_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] slot;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } eds_fifo_st_t;

  eds_fifo_st_t st;
  eds_fifo_st_t next_st;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (st.cnt != CW'(D));
  assign out_valid = (st.cnt != '0);
  assign out_data = st.slot[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer and count update
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.slot[st.wr] = in_data;
      next_st.wr = (st.wr == PW'(D - 1)) ? '0 : PW'(st.wr + 1'b1);
    end
    if (pop)
    begin
      next_st.rd = (st.rd == PW'(D - 1)) ? '0 : PW'(st.rd + 1'b1);
    end
    if (push && !pop)
    begin
      next_st.cnt = CW'(st.cnt + 1'b1);
    end
    else if (pop && !push)
    begin
      next_st.cnt = CW'(st.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

endmodule // eds_fifo

/* File: eds_stream.sv */
// Mode selection and transmit-only streaming of the dual mode serial memory
// Contract
// RULE_01: After reset (power-up) the block starts in transmit-only mode and streams the array.
// RULE_02: A valid high-to-low transition on SCL switches the block into bi-directional mode.
// RULE_03: Bi-directional mode is left only by reset, never by any logic event.
// RULE_04: Both modes have their own clock input but share the single SDA output.
// RULE_05: Streamed data goes out as 8-bit bytes, each followed by a ninth null bit with no data.
// RULE_06: Each new stream bit is driven on a rising edge of the transmit-only clock.
// RULE_07: Each streamed byte goes out most significant bit first.
// RULE_08: Bytes go out in consecutive address order and wrap from the last to the first.
// RULE_09: The host keeps SCL high for as long as streaming is wanted.
// RULE_10: The host initialises the link and no valid data is shown before that completes.
// RULE_11: In bi-directional mode SDA is held unchanged for at least 300 ns after SCL falls.
// RULE_12: Nine transmit-only clocks synchronise; the first MSB leaves on the tenth rising edge.
// RULE_13: SDA is released (not driven) during the synchronising clocks.
// RULE_14: The first streamed address after power-up is not defined and must not be relied on.
// RULE_15: The streamed array holds 128 locations of eight bits.
// RULE_16: A 7-bit byte address advances after each null bit and wraps from highest to zero.
module eds_stream
  import eds_pkg::*;
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic resetn,
  // Pins from the bus, asynchronous to clk
  input wire logic transmit_only_clock,
  input wire logic scl_in,
  // Shared data pin
  output logic sda_out,
  output logic sda_oe,
  // Bi-directional protocol side, on clk
  input wire logic bidir_sda_drive_low,
  // Array write port, on clk
  input wire logic mem_wr_en,
  input wire logic [6:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  // Status
  output logic bidir_mode,
  output logic [6:0] stream_addr
);

  typedef struct packed {
    logic [1:0] t_sync;
    logic t_prev;
    logic [1:0] s_sync;
    logic s_prev;
    eds_mode_t mode;
    logic [3:0] sync_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [6:0] byte_addr;
    logic [6:0] fetch_addr;
    logic pending;
    logic [5:0] hold_cnt;
    logic sda_out;
    logic sda_oe;
  } eds_st_t;

  eds_st_t st;
  eds_st_t next_st;
  logic t_rise;
  logic s_fall;
  logic rd_en;
  logic [7:0] rd_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  //////////////////////////////////////////////////////////////////////////////
  // Edge finding on the second synchroniser stage only
  assign t_rise = st.t_sync[1] && !st.t_prev;
  assign s_fall = !st.s_sync[1] && st.s_prev;

  // Prefetch one byte at a time; a slot is free whenever ready is high
  assign rd_en = (st.mode != EDS_BIDIR) && !st.pending && fifo_in_ready;

  // Take a byte only at the start of a byte period
  assign fifo_out_ready = (st.mode == EDS_STREAM) && !s_fall && t_rise
    && (st.bit_cnt == EDS_BIT_FIRST); // see RULE_07

  eds_mem u_mem (
    .clk(clk),
    .clk_en(clk_en),
    .rd_en(rd_en),
    .rd_addr(st.fetch_addr),
    .rd_data(rd_data),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data)
  ); // see RULE_15

  eds_fifo #(
    .W(EDS_BYTE_W),
    .D(EDS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_valid(st.pending),
    .in_ready(fifo_in_ready),
    .in_data(rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.t_sync = {st.t_sync[0], transmit_only_clock};
    next_st.t_prev = st.t_sync[1];
    next_st.s_sync = {st.s_sync[0], scl_in};
    next_st.s_prev = st.s_sync[1];

    // Prefetch path into the buffer
    if (rd_en)
    begin
      next_st.pending = 1'b1;
    end
    else if (st.pending && fifo_in_ready)
    begin
      next_st.pending = 1'b0;
      next_st.fetch_addr = eds_next_addr(st.fetch_addr); // see RULE_08
    end

    if (s_fall)
    begin
      // Any valid SCL fall ends streaming for good
      next_st.mode = EDS_BIDIR; // see RULE_02
      next_st.hold_cnt = EDS_HOLD_CYC; // see RULE_11
      next_st.pending = 1'b0;
      if (st.mode != EDS_BIDIR)
      begin
        // Drop the stream drive so a half-sent bit never fights the other bus
        next_st.sda_oe = 1'b0; // see RULE_04
      end
    end
    else
    begin
      case (st.mode)
        EDS_SYNC:
        begin
          next_st.sda_oe = 1'b0; // see RULE_13
          if (t_rise)
          begin
            next_st.sync_cnt = 4'(st.sync_cnt + 4'h1);
            if (next_st.sync_cnt == EDS_SYNC_EDGES)
            begin
              next_st.mode = EDS_STREAM; // see RULE_12
            end
          end
        end
        EDS_STREAM:
        begin
          if (t_rise)
          begin
            if (st.bit_cnt == EDS_BIT_FIRST)
            begin
              // Underrun holds the byte back to the next clock rise rather than send stale bits
              if (fifo_out_valid)
              begin
                next_st.sda_out = fifo_out_data[7]; // see RULE_07
                next_st.sda_oe = 1'b1; // see RULE_06
                next_st.shreg = {fifo_out_data[6:0], 1'b0};
                next_st.bit_cnt = 4'h1;
              end
            end
            else if (st.bit_cnt == EDS_NULL_BIT)
            begin
              next_st.sda_oe = 1'b0; // see RULE_05
              next_st.bit_cnt = EDS_BIT_FIRST;
              next_st.byte_addr = eds_next_addr(st.byte_addr); // see RULE_16
            end
            else
            begin
              next_st.sda_out = st.shreg[7]; // see RULE_06
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
            end
          end
        end
        EDS_BIDIR:
        begin
          // Stay here; the stream clock is disregarded
          next_st.mode = EDS_BIDIR; // see RULE_03
          if (st.hold_cnt != 6'h00)
          begin
            next_st.hold_cnt = 6'(st.hold_cnt - 6'h01); // see RULE_11
          end
          else
          begin
            next_st.sda_out = 1'b0; // see RULE_04
            next_st.sda_oe = bidir_sda_drive_low;
          end
        end
        default:
        begin
          next_st.mode = EDS_BIDIR;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; SCL synchroniser resets high so reset gives no false fall
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.s_sync <= 2'b11;
      st.s_prev <= 1'b1;
      st.mode <= EDS_SYNC; // see RULE_01
      st.bit_cnt <= EDS_BIT_FIRST;
      st.byte_addr <= EDS_ADDR_RESET; // see RULE_14
      st.fetch_addr <= EDS_ADDR_RESET;
      st.sda_out <= 1'b1;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // Pin and address outputs straight from flip-flops; bidir_mode decoded from the mode register
  assign sda_out = st.sda_out;
  assign sda_oe = st.sda_oe; // see RULE_10
  assign bidir_mode = (st.mode == EDS_BIDIR);
  assign stream_addr = st.byte_addr;

endmodule // eds_stream

/* File: eds_stream_asserts.sv */
// Checker of mode selection and stream timing at the stream block ports
module eds_stream_asserts
  import eds_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins and drive request
  input wire logic transmit_only_clock,
  input wire logic scl_in,
  input wire logic bidir_sda_drive_low,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Status
  input wire logic bidir_mode,
  input wire logic [6:0] stream_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic vq, sq;
  logic [3:0] n_rise;
  logic [5:0] since_rise, since_fall;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  //////////
  // Raw pin edges; seen before the block's own synchronisers, so bounds are loose
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vq <= 1'b0;
      sq <= 1'b1;
      n_rise <= 4'h0;
      since_rise <= 6'h3f;
      since_fall <= 6'h3f;
    end
    else
    begin
      vq <= transmit_only_clock;
      sq <= scl_in;
      if (transmit_only_clock && !vq && n_rise != 4'hf)
        n_rise <= n_rise + 4'h1;
      since_rise <= (transmit_only_clock && !vq) ? 6'h00
        : since_rise + {5'h00, since_rise != 6'h3f};
      since_fall <= (!scl_in && sq) ? 6'h00 : since_fall + {5'h00, since_fall != 6'h3f};
    end
  end
  //////////
  property p_start; $rose(resetn) |-> !bidir_mode && !sda_oe; endproperty
  a_start: assert property (p_start) else $error("not streaming after reset");
  property p_switch; $rose(bidir_mode) |-> !$past(scl_in, 2); endproperty
  a_switch: assert property (p_switch) else $error("mode change without scl fall");
  property p_sticky; bidir_mode |=> bidir_mode; endproperty
  a_sticky: assert property (p_sticky) else $error("left bidirectional mode");
  property p_quiet; n_rise < 4'ha && !bidir_mode |-> !sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("sda driven while synchronising");
  property p_first; $rose(n_rise == 4'ha) |-> ##[2:6] sda_oe; endproperty
  a_first: assert property (p_first) else $error("no first bit on tenth edge");
  property p_launch;
    !bidir_mode && $changed({sda_out, sda_oe}) |-> since_rise inside {[6'h01:6'h06]};
  endproperty
  a_launch: assert property (p_launch) else $error("sda moved without clock rise");
  property p_null;
    !bidir_mode && $fell(sda_oe) |-> stream_addr == $past(stream_addr) + 7'h01;
  endproperty
  a_null: assert property (p_null) else $error("address stuck at null bit");
  property p_addr; $changed(stream_addr) && !bidir_mode |-> !sda_oe; endproperty
  a_addr: assert property (p_addr) else $error("address moved inside a byte");
  property p_hold;
    bidir_mode && !$rose(bidir_mode) && $changed({sda_out, sda_oe}) |-> since_fall >= EDS_HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved inside scl hold");
  property p_follow;
    bidir_mode && since_fall == 6'h3f |-> sda_oe == $past(bidir_sda_drive_low) && !sda_out;
  endproperty
  a_follow: assert property (p_follow) else $error("shared sda not driven low");
  // Main scenarios
  c_byte: cover property ($rose(sda_oe) && !bidir_mode);
  c_wrap: cover property ($changed(stream_addr) && stream_addr == 7'h00);
  c_bidir: cover property ($rose(bidir_mode));
endmodule // eds_stream_asserts

bind eds_stream eds_stream_asserts eds_stream_asserts_inst (.clk, .resetn, .transmit_only_clock,
  .scl_in, .bidir_sda_drive_low, .sda_out, .sda_oe, .bidir_mode, .stream_addr);

/* File: eds_host.sv */
// Display host model: makes the transmit-only clock and SCL, collects streamed bytes
module eds_host
(
  // Control from the bench
  input wire logic resetn,
  input wire logic run,
  input wire logic scl_low,
  // Pins
  input wire logic sda_wire,
  output logic transmit_only_clock,
  output logic scl,
  // Received stream
  output logic [7:0] rx_byte,
  output logic rx_null,
  output int rx_count
);
  timeunit 1ns;
  timeprecision 100ps;
  int n_rise;
  int p;
  logic [7:0] sh;
  // SCL held high while streaming is wanted
  assign scl = !scl_low;
  // 64 ns clock, standing still low whenever run is off
  initial
  begin
    transmit_only_clock = 1'b0;
    #3;
    forever
    begin
      // Start 2 ns off the clk edge so the pin never moves where the block samples it
      if (!run)
      begin
        wait (run);
        #2;
      end
      #32 transmit_only_clock = 1'b1;
      #32 transmit_only_clock = 1'b0;
    end
  end
  // Read the previous bit just before it can change; nine rises only synchronise
  always @(posedge transmit_only_clock or negedge resetn)
  begin
    if (!resetn)
    begin
      n_rise = 0;
      rx_count = 0;
      rx_null = 1'b1;
      rx_byte = 8'h00;
      sh = 8'h00;
    end
    else
    begin
      n_rise = n_rise + 1;
      if (n_rise >= 11)
      begin
        p = (n_rise - 11) % 9;
        if (p == 8)
          rx_null = sda_wire;
        else
          sh = {sh[6:0], sda_wire};
        if (p == 7)
        begin
          rx_byte = sh;
          rx_count++;
        end
      end
    end
  end
endmodule // eds_host

/* File: eds_stream_test.sv */
// Testbench of the stream block with host model and checker
module eds_stream_test
  import eds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
  logic clk, resetn, run, scl_low, drive_low, wr_en, tvc, scl;
  logic sda_out, sda_oe, bidir_mode, rx_null;
  logic clk_en = 1'b1;
  logic [6:0] wr_addr, stream_addr;
  logic [7:0] wr_data, rx_byte;
  wire logic sda_wire;
  int rx_count;
  int errors = 0;
  int num_checks = 0;
  // Pull-up on the shared data line
  assign sda_wire = sda_oe ? sda_out : 1'b1;
  eds_stream eds_stream_inst (.clk, .clk_en, .resetn, .transmit_only_clock(tvc), .scl_in(scl),
    .sda_out, .sda_oe, .bidir_sda_drive_low(drive_low), .mem_wr_en(wr_en),
    .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .bidir_mode, .stream_addr);
  eds_host eds_host_inst (.resetn, .run, .scl_low, .sda_wire, .transmit_only_clock(tvc), .scl,
    .rx_byte, .rx_null, .rx_count);
  //////////
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Bounded wait for the host to collect n bytes
  task automatic wait_bytes(input int n);
    for (int k = 0; k < 2000 && rx_count < n; k++)
      @(posedge clk);
    `CHK("bytes", n, rx_count)
  endtask
  // Each byte holds its own address, so the undefined start is read from the stream
  task automatic t_load;
    for (int a = 0; a < EDS_MEM_DEPTH; a++)
    begin
      wr_en <= 1'b1;
      wr_addr <= 7'(a);
      wr_data <= {7'(a), 1'b1};
      @(posedge clk);
    end
    wr_en <= 1'b0;
  endtask
  task automatic t_sync;
    run <= 1'b1;
    repeat (9) @(posedge tvc);
    repeat (5) @(posedge clk);
    `CHK("sync oe", 1'b0, sda_oe)
    `CHK("mode", 1'b0, bidir_mode)
    @(posedge tvc);
    repeat (6) @(posedge clk);
    `CHK("first oe", 1'b1, sda_oe)
  endtask
  // Runs past the wrap of the array
  task automatic t_stream;
    logic [6:0] first;
    // The first byte is prefetched before its cell is loaded, so the run starts at the second
    wait_bytes(2);
    first = rx_byte[7:1];
    `CHK("low bit", 1'b1, rx_byte[0])
    for (int k = 1; k <= 130; k++)
    begin
      wait_bytes(k + 2);
      `CHK("byte", {7'(first + k), 1'b1}, rx_byte)
      `CHK("null", 1'b1, rx_null)
    end
  endtask
  task automatic t_bidir;
    int n0;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    scl_low <= 1'b1;
    for (int k = 0; k < 20 && bidir_mode !== 1'b1; k++)
      @(posedge clk);
    `CHK("mode", 1'b1, bidir_mode)
    drive_low <= 1'b1;
    repeat (EDS_HOLD_CYC - 6) @(posedge clk);
    `CHK("held oe", 1'b0, sda_oe)
    repeat (12) @(posedge clk);
    `CHK("sda", 1'b0, sda_wire)
    // A low enable freezes the pin drive although the request drops
    clk_en <= 1'b0;
    drive_low <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("frozen oe", 1'b1, sda_oe)
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("thawed oe", 1'b0, sda_oe)
    drive_low <= 1'b0;
    scl_low <= 1'b0;
    run <= 1'b1;
    n0 = rx_count;
    wait_bytes(n0 + 3);
    `CHK("mode", 1'b1, bidir_mode)
    `CHK("released", 8'hff, rx_byte)
    run <= 1'b0;
  endtask
  task automatic t_repower;
    repeat (20) @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("mode", 1'b0, bidir_mode)
    resetn <= 1'b1;
    run <= 1'b1;
    wait_bytes(3);
    `CHK("mode", 1'b0, bidir_mode)
    `CHK("byte", 1'b1, rx_byte[0])
  endtask
  //////////
  // Clock of 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    resetn <= 1'b0;
    {run, scl_low, drive_low, wr_en, wr_addr, wr_data} <= '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_load;
    t_sync;
    t_stream;
    t_bidir;
    t_repower;
    test_done;
  end
  // Watchdog well beyond the expected run of about 85 us
  initial
  begin
    #150000;
    errors++;
    test_done;
  end
endmodule // eds_stream_test
